// ### bist_reset_wake_control_regs.sv
/*
 * Self-test, global reset and wake-up control register bank on an AHB-Lite slave.
 * Zero-wait slave: hreadyout is always high, responses always OKAY.
 * Assumes the memory test engines hold their done/fail/count levels while bist_run is high.
 */
// Chosen here: the AHB-Lite slave port.
// How it works
// R01: info bit 15 is 0 during self-test, 1 once both memories finished.
// R02: bit 12 goes 1 when transmit memory test finishes, else 0.
// R03: bit 11 shows transmit memory test finished with failure.
// R04: bits 10:8 hold the transmit memory fail count, zero without failure.
// R05: bit 4 goes 1 when receive memory test finishes, else 0.
// R06: bit 3 shows receive memory test failed.
// R07: bits 2:0 hold the receive memory fail count, zero without failure.
// R08: host should reset the device after running the self-test.
// R09: global reset bit 3 written 1 starts self-test, written 0 stops it; here a 1 starts it only when bit 3 was 0 before the write.
// R10: while bit 1 is set, queue memories flush and queue manager resets.
// R11: while bit 0 is set, all registers return to defaults except straps.
// R12: bit 0 never clears itself; host holds it at least 10 ms.
// R13: wake-up control bit 7 enables magic packet detection, resets to 0.
// R14: wake-up control bits 3:0 enable wake patterns 3..0, reset to 0.
// R15: writes to read-only info and reserved wake-up bits are ignored.
`timescale 1ns/100ps
`default_nettype none
module bist_reset_wake_control_regs #(
	parameter int HOLD_CYCLES = bist_wake_pkg::SOFT_RESET_HOLD_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire bist_wake_pkg::bist_result_s bist_result,
	output logic bist_run,
	output logic queue_flush,
	output logic soft_reset_active,
	output logic soft_reset_hold_met,
	output bist_wake_pkg::wake_ctrl_s wake_ctrl,
	output logic irq
);
	import bist_wake_pkg::*;

	typedef struct packed {
		logic dp_write;
		logic dp_read;
		logic [9:0] dp_index;
		bist_state_e fsm;
		logic [11:0] grr_spare_hi;
		logic grr_spare2;
		logic bist_start;
		logic queue_reset;
		logic soft_reset;
		logic tx_completed;
		logic tx_failed;
		logic [2:0] tx_fail_count;
		logic rx_completed;
		logic rx_failed;
		logic [2:0] rx_fail_count;
		logic magic_en;
		logic [3:0] pattern_en;
		logic [2:0] irq_status;
		logic [2:0] irq_mask;
		logic [21:0] hold_count;
		logic hold_met;
	} state_s;

	localparam logic [21:0] HOLD_LAST = 22'(HOLD_CYCLES - 1);

	state_s st;
	state_s next_st;
	logic take;
	logic wr_grr;
	logic [2:0] irq_set;

	// hsize is not checked: every access is treated as a whole word
	assign take = hsel && htrans[1] && hready;
	assign wr_grr = st.dp_write && (st.dp_index == IDX_GLOBAL_RESET);

	function automatic logic [15:0] info_word(input state_s s);
		info_word = 16'h0000;
		info_word[INFO_DONE_BIT] = s.tx_completed && s.rx_completed; // [R01]
		info_word[INFO_TX_DONE_BIT] = s.tx_completed; // [R02]
		info_word[INFO_TX_FAIL_BIT] = s.tx_failed; // [R03]
		info_word[INFO_TX_COUNT_LSB +: 3] = s.tx_fail_count; // [R04]
		info_word[INFO_RX_DONE_BIT] = s.rx_completed; // [R05]
		info_word[INFO_RX_FAIL_BIT] = s.rx_failed; // [R06]
		info_word[INFO_RX_COUNT_LSB +: 3] = s.rx_fail_count; // [R07]
	endfunction

	always_comb begin
		next_st = st;
		irq_set = IRQ_RESET;
		next_st.dp_write = take && hwrite;
		next_st.dp_read = take && !hwrite;
		next_st.dp_index = haddr[11:2];

		// self-test engine sequencing
		case (st.fsm)
			BIST_IDLE: begin
			end
			BIST_RUNNING: begin
				if (bist_result.tx_done && !st.tx_completed) begin
					next_st.tx_completed = 1'b1; // [R02]
					next_st.tx_failed = bist_result.tx_fail; // [R03]
					next_st.tx_fail_count = bist_result.tx_fail_count; // [R04]
					irq_set[IRQ_TX_DONE_BIT] = 1'b1;
					irq_set[IRQ_FAIL_BIT] = bist_result.tx_fail;
				end
				if (bist_result.rx_done && !st.rx_completed) begin
					next_st.rx_completed = 1'b1; // [R05]
					next_st.rx_failed = bist_result.rx_fail; // [R06]
					next_st.rx_fail_count = bist_result.rx_fail_count; // [R07]
					irq_set[IRQ_RX_DONE_BIT] = 1'b1;
					irq_set[IRQ_FAIL_BIT] = irq_set[IRQ_FAIL_BIT] || bist_result.rx_fail;
				end
				if (next_st.tx_completed && next_st.rx_completed) begin
					next_st.fsm = BIST_FINISHED;
				end
			end
			BIST_FINISHED: begin
			end
			default: begin
				next_st.fsm = BIST_IDLE;
			end
		endcase

		// register writes land in the data phase, with hwdata of that phase
		if (st.dp_write) begin
			case (st.dp_index)
				IDX_GLOBAL_RESET: begin
					next_st.grr_spare_hi = hwdata[GRR_SPARE_HI_LSB +: 12];
					next_st.grr_spare2 = hwdata[GRR_SPARE2_BIT];
					next_st.bist_start = hwdata[GRR_BIST_START_BIT];
					next_st.queue_reset = hwdata[GRR_QUEUE_RESET_BIT]; // [R10]
					next_st.soft_reset = hwdata[GRR_SOFT_RESET_BIT]; // [R12]
					if (hwdata[GRR_BIST_START_BIT] && !st.bist_start) begin
						// a fresh start discards the previous results
						next_st.fsm = BIST_RUNNING; // [R09]
						next_st.tx_completed = 1'b0;
						next_st.tx_failed = 1'b0;
						next_st.tx_fail_count = FAIL_COUNT_RESET;
						next_st.rx_completed = 1'b0;
						next_st.rx_failed = 1'b0;
						next_st.rx_fail_count = FAIL_COUNT_RESET;
						irq_set = IRQ_RESET;
					end else if (!hwdata[GRR_BIST_START_BIT]) begin
						// stop keeps whatever results were captured so far
						next_st.fsm = BIST_IDLE; // [R09]
					end
				end
				IDX_WAKEUP_CTRL: begin
					next_st.magic_en = hwdata[WFC_MAGIC_BIT]; // [R13]
					next_st.pattern_en = hwdata[WFC_PATTERN_LSB +: 4]; // [R14] [R15]
				end
				IDX_IRQ_STATUS: begin
					next_st.irq_status = st.irq_status & ~hwdata[2:0];
				end
				IDX_IRQ_MASK: begin
					next_st.irq_mask = hwdata[2:0];
				end
				default: begin
					// self-test info and unmapped words take no writes
				end
			endcase
		end
		// set wins over a clear in the same cycle
		next_st.irq_status = next_st.irq_status | irq_set;

		// hold timer: not a register, so it survives the soft reset it measures
		if (st.soft_reset) begin
			if (st.hold_count != HOLD_LAST) begin
				next_st.hold_count = st.hold_count + 22'h000001;
			end else begin
				next_st.hold_met = 1'b1; // [R12]
			end
		end else begin
			next_st.hold_count = HOLD_COUNT_RESET;
			next_st.hold_met = 1'b0;
		end

		// soft reset holds every register at its default; only bit 0 itself stays
		if (st.soft_reset) begin
			next_st.fsm = BIST_IDLE; // [R11]
			next_st.grr_spare_hi = GRR_SPARE_HI_RESET;
			next_st.grr_spare2 = 1'b0;
			next_st.bist_start = 1'b0;
			next_st.queue_reset = 1'b0;
			next_st.tx_completed = 1'b0;
			next_st.tx_failed = 1'b0;
			next_st.tx_fail_count = FAIL_COUNT_RESET;
			next_st.rx_completed = 1'b0;
			next_st.rx_failed = 1'b0;
			next_st.rx_fail_count = FAIL_COUNT_RESET;
			next_st.magic_en = 1'b0;
			next_st.pattern_en = PATTERN_EN_RESET;
			next_st.irq_status = IRQ_RESET;
			next_st.irq_mask = IRQ_RESET;
			if (wr_grr) begin
				next_st.soft_reset = hwdata[GRR_SOFT_RESET_BIT];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '{fsm: BIST_IDLE, grr_spare_hi: GRR_SPARE_HI_RESET, dp_index: 10'h000,
				tx_fail_count: FAIL_COUNT_RESET, rx_fail_count: FAIL_COUNT_RESET,
				pattern_en: PATTERN_EN_RESET, irq_status: IRQ_RESET, irq_mask: IRQ_RESET,
				hold_count: HOLD_COUNT_RESET, default: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// read data is muxed from flops by the latched data-phase index
	always_comb begin
		hrdata = 32'h00000000;
		if (st.dp_read) begin
			case (st.dp_index)
				IDX_SELFTEST_INFO: hrdata[15:0] = info_word(st);
				IDX_GLOBAL_RESET: hrdata[15:0] = {st.grr_spare_hi, st.bist_start, st.grr_spare2,
					st.queue_reset, st.soft_reset};
				IDX_WAKEUP_CTRL: hrdata[15:0] = {8'h00, st.magic_en, 3'h0, st.pattern_en}; // [R15]
				IDX_IRQ_STATUS: hrdata[2:0] = st.irq_status;
				IDX_IRQ_MASK: hrdata[2:0] = st.irq_mask;
				default: hrdata = 32'h00000000;
			endcase
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign bist_run = (st.fsm == BIST_RUNNING);
	assign queue_flush = st.queue_reset; // [R10]
	assign soft_reset_active = st.soft_reset; // [R11]
	assign soft_reset_hold_met = st.hold_met;
	assign wake_ctrl = '{magic_packet_detect_enable: st.magic_en, wake_pattern_enable: st.pattern_en};
	assign irq = |(st.irq_status & st.irq_mask);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_done_bit;
		st.dp_read && st.dp_index == IDX_SELFTEST_INFO |-> hrdata[15] == (st.tx_completed && st.rx_completed);
	endproperty
	a_done_bit: assert property (p_done_bit) else $error("done bit disagrees with completions"); // [R01]

	// completion and finish are judged in one cycle, so a running test never shows done
	property p_running_not_done;
		bist_run |-> !(st.tx_completed && st.rx_completed);
	endproperty
	a_running_not_done: assert property (p_running_not_done) else $error("done shown while self-test runs"); // [R01]

	property p_both_done_ends;
		bist_run && bist_result.tx_done && bist_result.rx_done |=> !bist_run;
	endproperty
	a_both_done_ends: assert property (p_both_done_ends) else $error("self-test kept running after finish"); // [R01]

	property p_tx_completed;
		$rose(st.tx_completed) |-> $past(bist_result.tx_done) && $past(st.fsm) == BIST_RUNNING;
	endproperty
	a_tx_completed: assert property (p_tx_completed) else $error("tx completion without engine done"); // [R02]

	property p_tx_failed;
		$rose(st.tx_completed) |-> st.tx_failed == $past(bist_result.tx_fail);
	endproperty
	a_tx_failed: assert property (p_tx_failed) else $error("tx fail flag not captured"); // [R03]

	property p_tx_count;
		$rose(st.tx_completed) |-> st.tx_fail_count == $past(bist_result.tx_fail_count);
	endproperty
	a_tx_count: assert property (p_tx_count) else $error("tx fail count not captured"); // [R04]

	property p_rx_completed;
		$rose(st.rx_completed) |-> $past(bist_result.rx_done) && $past(st.fsm) == BIST_RUNNING;
	endproperty
	a_rx_completed: assert property (p_rx_completed) else $error("rx completion without engine done"); // [R05]

	property p_rx_failed;
		$rose(st.rx_completed) |-> st.rx_failed == $past(bist_result.rx_fail);
	endproperty
	a_rx_failed: assert property (p_rx_failed) else $error("rx fail flag not captured"); // [R06]

	property p_rx_count;
		$rose(st.rx_completed) |-> st.rx_fail_count == $past(bist_result.rx_fail_count);
	endproperty
	a_rx_count: assert property (p_rx_count) else $error("rx fail count not captured"); // [R07]

	property p_bist_start;
		wr_grr && hwdata[3] && !st.bist_start && !st.soft_reset |=> bist_run && !st.tx_completed && !st.rx_completed;
	endproperty
	a_bist_start: assert property (p_bist_start) else $error("self-test did not start"); // [R09]

	property p_bist_stop;
		wr_grr && !hwdata[3] |=> !bist_run [*2];
	endproperty
	a_bist_stop: assert property (p_bist_stop) else $error("self-test did not stop"); // [R09]

	property p_queue_flush;
		wr_grr && !st.soft_reset |=> queue_flush == $past(hwdata[1]);
	endproperty
	a_queue_flush: assert property (p_queue_flush) else $error("queue flush does not follow bit 1"); // [R10]

	property p_soft_defaults;
		soft_reset_active |=> wake_ctrl == '0 && !irq && !bist_run && !queue_flush;
	endproperty
	a_soft_defaults: assert property (p_soft_defaults) else $error("register not at default in soft reset"); // [R11]

	property p_soft_sticky;
		soft_reset_active && !wr_grr |=> soft_reset_active;
	endproperty
	a_soft_sticky: assert property (p_soft_sticky) else $error("soft reset cleared itself"); // [R12]

	property p_hold_met;
		$rose(soft_reset_hold_met) |-> $past(st.hold_count) == HOLD_LAST && $past(soft_reset_active);
	endproperty
	a_hold_met: assert property (p_hold_met) else $error("hold time flagged early"); // [R12]

	property p_wake_write;
		st.dp_write && st.dp_index == IDX_WAKEUP_CTRL && !st.soft_reset
			|=> wake_ctrl == {$past(hwdata[7]), $past(hwdata[3:0])};
	endproperty
	a_wake_write: assert property (p_wake_write) else $error("wake-up enables not written"); // [R13] [R14]

	property p_info_ro;
		st.dp_write && st.dp_index == IDX_SELFTEST_INFO && st.fsm != BIST_RUNNING && !st.soft_reset
			|=> $stable(info_word(st));
	endproperty
	a_info_ro: assert property (p_info_ro) else $error("write changed self-test info"); // [R15]

	c_bist_finished: cover property (st.fsm == BIST_RUNNING ##1 st.fsm == BIST_FINISHED);
	c_bist_failed: cover property ($rose(st.tx_failed) || $rose(st.rx_failed));
	c_hold_met: cover property ($rose(soft_reset_hold_met));
	c_irq: cover property ($rose(irq));
	c_soft_release: cover property ($fell(soft_reset_active) && soft_reset_hold_met);
endmodule
`default_nettype wire

// ### bist_wake_pkg.sv
/*
 * Shared definitions for the self-test, reset and wake-up control register bank:
 * register indices, field positions, reset values, timing counts, state codes and carriers.
 * Assumes a 200 MHz device clock and a 32-bit AHB-Lite register bus.
 */
`default_nettype none
package bist_wake_pkg;
	// register indices; the byte address on the bus is four times the index
	localparam logic [9:0] IDX_SELFTEST_INFO = 10'h124;
	localparam logic [9:0] IDX_GLOBAL_RESET = 10'h126;
	localparam logic [9:0] IDX_WAKEUP_CTRL = 10'h12a;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h1f0;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h1f1;
	// self-test info fields
	localparam int INFO_DONE_BIT = 15;
	localparam int INFO_TX_DONE_BIT = 12;
	localparam int INFO_TX_FAIL_BIT = 11;
	localparam int INFO_TX_COUNT_LSB = 8;
	localparam int INFO_RX_DONE_BIT = 4;
	localparam int INFO_RX_FAIL_BIT = 3;
	localparam int INFO_RX_COUNT_LSB = 0;
	// global reset fields
	localparam int GRR_BIST_START_BIT = 3;
	localparam int GRR_SPARE2_BIT = 2;
	localparam int GRR_QUEUE_RESET_BIT = 1;
	localparam int GRR_SOFT_RESET_BIT = 0;
	localparam int GRR_SPARE_HI_LSB = 4;
	// wake-up control fields
	localparam int WFC_MAGIC_BIT = 7;
	localparam int WFC_PATTERN_LSB = 0;
	// interrupt status/mask bits
	localparam int IRQ_TX_DONE_BIT = 0;
	localparam int IRQ_RX_DONE_BIT = 1;
	localparam int IRQ_FAIL_BIT = 2;
	// reset values
	localparam logic [11:0] GRR_SPARE_HI_RESET = 12'h000;
	localparam logic [3:0] PATTERN_EN_RESET = 4'h0;
	localparam logic [2:0] FAIL_COUNT_RESET = 3'h0;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam logic [21:0] HOLD_COUNT_RESET = 22'h000000;
	// soft reset minimum hold time
	localparam int SOFT_RESET_HOLD_MS = 10;
	localparam int CLOCK_KHZ = 200000;
	localparam int SOFT_RESET_HOLD_CYCLES = SOFT_RESET_HOLD_MS * CLOCK_KHZ;

	typedef enum logic [2:0] {
		BIST_IDLE = 3'b001,
		BIST_RUNNING = 3'b010,
		BIST_FINISHED = 3'b100
	} bist_state_e;

	// result levels from the memory test engines, valid while the done level is high
	typedef struct packed {
		logic tx_done;
		logic tx_fail;
		logic [2:0] tx_fail_count;
		logic rx_done;
		logic rx_fail;
		logic [2:0] rx_fail_count;
	} bist_result_s;

	typedef struct packed {
		logic magic_packet_detect_enable;
		logic [3:0] wake_pattern_enable;
	} wake_ctrl_s;

	function automatic logic [31:0] byte_addr(input logic [9:0] idx);
		byte_addr = {20'h00000, idx, 2'b00};
	endfunction
endpackage
`default_nettype wire

// ### mem_test_engine_model.sv
/*
 * Behavioural model of the transmit and receive memory test engines that
 * answer the register bank's self-test run request.
 * Assumes the bench sets the delays and fail counts before a run starts.
 */
`timescale 1ns/100ps
`default_nettype none
module mem_test_engine_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic bist_run,
	input wire logic [7:0] tx_delay,
	input wire logic [7:0] rx_delay,
	input wire logic [2:0] tx_count,
	input wire logic [2:0] rx_count,
	output var bist_wake_pkg::bist_result_s bist_result
);
	import bist_wake_pkg::*;
	logic [7:0] cnt;
	logic tx_done;
	logic rx_done;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 8'h00;
		end else if (!bist_run) begin
			cnt <= 8'h00;
		end else if (cnt != 8'hff) begin
			cnt <= cnt + 8'h01;
		end
	end
	assign tx_done = bist_run && (cnt >= tx_delay);
	assign rx_done = bist_run && (cnt >= rx_delay);
	// fail and count lines carry junk until done, so capture must key on done alone
	always_comb begin
		bist_result.tx_done = tx_done;
		bist_result.tx_fail = tx_done ? (tx_count != 3'h0) : cnt[0];
		bist_result.tx_fail_count = tx_done ? tx_count : ~cnt[2:0];
		bist_result.rx_done = rx_done;
		bist_result.rx_fail = rx_done ? (rx_count != 3'h0) : ~cnt[0];
		bist_result.rx_fail_count = rx_done ? rx_count : cnt[3:1];
	end
endmodule
`default_nettype wire

// ### tb_top.sv
/*
 * Self-checking bench for the self-test, reset and wake-up register bank.
 * Assumes a zero-wait AHB-Lite slave and the memory test engine model.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import bist_wake_pkg::*;
	typedef struct packed {
		logic [9:0] idx;
		logic [15:0] wd;
		logic [15:0] rd;
	} row_s;
	localparam int HOLD = 20;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, bist_run, queue_flush, srst, hold_met, irq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, txc, rxc;
	logic [7:0] txd, rxd;
	bist_result_s res;
	wake_ctrl_s wake_ctrl;
	int error_cnt, tests_run, i;
	row_s rows[14];

	bist_reset_wake_control_regs #(.HOLD_CYCLES(HOLD)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bist_result(res), .bist_run(bist_run),
		.queue_flush(queue_flush), .soft_reset_active(srst), .soft_reset_hold_met(hold_met),
		.wake_ctrl(wake_ctrl), .irq(irq));
	mem_test_engine_model eng_u (.hclk(hclk), .hresetn(hresetn), .bist_run(bist_run), .tx_delay(txd),
		.rx_delay(rxd), .tx_count(txc), .rx_count(rxc), .bist_result(res));

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single transfer: address phase held until hready, then data phase held until hready
	task automatic xfer(input logic w, input logic [9:0] idx, input logic [15:0] wd, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {20'h00000, idx, 2'b00};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= {16'h0000, wd};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0);
		#1;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [15:0] wd);
		logic [31:0] r;
		xfer(1'b1, idx, wd, r);
	endtask

	task automatic rd_chk(input logic [9:0] idx, input logic [15:0] exp);
		logic [31:0] r;
		xfer(1'b0, idx, 16'h0000, r);
		chk(r, {16'h0000, exp});
	endtask

	task automatic run_test(input logic [7:0] td, input logic [7:0] rdl, input logic [2:0] tc,
		input logic [2:0] rc, input logic [15:0] exp_info);
		int n;
		txd <= td;
		rxd <= rdl;
		txc <= tc;
		rxc <= rc;
		wr(IDX_GLOBAL_RESET, 16'h0000);
		wr(IDX_GLOBAL_RESET, 16'h0008);
		chk({31'h0, bist_run}, 32'h1);
		rd_chk(IDX_SELFTEST_INFO, 16'h0000);
		n = 0;
		while (bist_run === 1'b1 && n < 300) begin
			@(posedge hclk);
			n++;
		end
		#1;
		chk({31'h0, bist_run}, 32'h0);
		rd_chk(IDX_SELFTEST_INFO, exp_info);
	endtask

	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		give_verdict;
	end

	initial begin
		rows = '{'{IDX_WAKEUP_CTRL, 16'h0001, 16'h0001}, '{IDX_WAKEUP_CTRL, 16'h0002, 16'h0002},
			'{IDX_WAKEUP_CTRL, 16'h0004, 16'h0004}, '{IDX_WAKEUP_CTRL, 16'h0008, 16'h0008},
			'{IDX_WAKEUP_CTRL, 16'h0080, 16'h0080}, '{IDX_WAKEUP_CTRL, 16'hffff, 16'h008f},
			'{IDX_WAKEUP_CTRL, 16'hff70, 16'h0000}, '{IDX_SELFTEST_INFO, 16'hffff, 16'h0000},
			'{IDX_GLOBAL_RESET, 16'hfff4, 16'hfff4}, '{IDX_GLOBAL_RESET, 16'h0000, 16'h0000},
			'{IDX_IRQ_MASK, 16'hffff, 16'h0007}, '{IDX_IRQ_MASK, 16'h0000, 16'h0000},
			'{IDX_IRQ_STATUS, 16'h0007, 16'h0000}, '{10'h125, 16'hffff, 16'h0000}};
		error_cnt = 0;
		tests_run = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		hsize = 3'h2;
		txd = 8'h05;
		rxd = 8'h09;
		txc = 3'h0;
		rxc = 3'h0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(IDX_SELFTEST_INFO, 16'h0000);
		rd_chk(IDX_GLOBAL_RESET, 16'h0000);
		rd_chk(IDX_WAKEUP_CTRL, 16'h0000);
		for (i = 0; i < 14; i++) begin
			wr(rows[i].idx, rows[i].wd);
			rd_chk(rows[i].idx, rows[i].rd);
			if (rows[i].idx == IDX_WAKEUP_CTRL) begin
				chk({27'h0, wake_ctrl}, {27'h0, rows[i].wd[7], rows[i].wd[3:0]});
			end
		end
		wr(IDX_IRQ_MASK, 16'h0007);
		run_test(8'h05, 8'h09, 3'h0, 3'h5, 16'h901d);
		chk({31'h0, irq}, 32'h1);
		rd_chk(IDX_IRQ_STATUS, 16'h0007);
		wr(IDX_IRQ_STATUS, 16'h0007);
		chk({31'h0, irq}, 32'h0);
		wr(IDX_IRQ_MASK, 16'h0000);
		run_test(8'h0c, 8'h03, 3'h3, 3'h0, 16'h9b10);
		chk({31'h0, irq}, 32'h0);
		rd_chk(IDX_IRQ_STATUS, 16'h0007);
		wr(IDX_IRQ_MASK, 16'h0007);
		chk({31'h0, irq}, 32'h1);
		wr(IDX_IRQ_STATUS, 16'h0007);
		chk({31'h0, irq}, 32'h0);
		// slow receive engine: stop after only the transmit side finished, its result must stay
		txd <= 8'h00;
		rxd <= 8'hc8;
		wr(IDX_GLOBAL_RESET, 16'h0000);
		wr(IDX_GLOBAL_RESET, 16'h0008);
		wr(IDX_GLOBAL_RESET, 16'h0000);
		chk({31'h0, bist_run}, 32'h0);
		rd_chk(IDX_SELFTEST_INFO, 16'h1b00);
		wr(IDX_GLOBAL_RESET, 16'h0002);
		chk({31'h0, queue_flush}, 32'h1);
		wr(IDX_GLOBAL_RESET, 16'h0000);
		chk({31'h0, queue_flush}, 32'h0);
		// host resets the device after self-test, holding soft reset past the minimum
		wr(IDX_WAKEUP_CTRL, 16'h008f);
		wr(IDX_GLOBAL_RESET, 16'h00f3);
		repeat (3) @(posedge hclk);
		#1;
		chk({31'h0, srst}, 32'h1);
		chk({31'h0, hold_met}, 32'h0);
		chk({27'h0, wake_ctrl}, 32'h0);
		chk({30'h0, queue_flush, irq}, 32'h0);
		rd_chk(IDX_GLOBAL_RESET, 16'h0001);
		rd_chk(IDX_WAKEUP_CTRL, 16'h0000);
		repeat (HOLD) @(posedge hclk);
		#1;
		chk({31'h0, hold_met}, 32'h1);
		wr(IDX_GLOBAL_RESET, 16'h0000);
		#5;
		chk({30'h0, srst, hold_met}, 32'h0);
		// second power-up reset in mid-run
		wr(IDX_WAKEUP_CTRL, 16'h0085);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		#1;
		chk({27'h0, wake_ctrl}, 32'h0);
		@(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(IDX_WAKEUP_CTRL, 16'h0000);
		give_verdict;
	end
endmodule
`default_nettype wire
